// ===== bench/itci_bus_model.sv
/*
 * Behavioural model of the other parties on the two-wire bus.
 * Assumes the caller is just past a rising edge of clock_i when it
 * calls put, and that both lines carry pull-ups.
 */
module itci_bus_model (
   input wire logic clock_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pull-ups hold both lines high while nobody drives them
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // Drive both lines, then hold them for n cycles
   task automatic put(input logic scl_v, input logic sda_v, input int n);
      scl_o <= scl_v;
      sda_o <= sda_v;
      repeat (n) @(posedge clock_i);
   endtask

endmodule

// ===== bench/itci_tb_top.sv
/*
 * Self-checking testbench for the time-out, prescaler and masked status
 * block. Assumes the package and the bus model are compiled first.
 */
module itci_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_TO = itci_pkg::TO_STATUS_ADDR;
   localparam logic [31:0] A_SET = itci_pkg::IRQ_EN_SET_ADDR;
   localparam logic [31:0] A_CLR = itci_pkg::IRQ_EN_CLR_ADDR;
   localparam logic [31:0] A_INT = itci_pkg::INTERVAL_ADDR;
   localparam logic [31:0] A_DIV = itci_pkg::DIVIDER_ADDR;
   localparam logic [31:0] A_MSK = itci_pkg::MASKED_STAT_ADDR;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [31:0] addr_i = '0;
   logic [31:0] wr_data_i = '0;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [8:0] flg = 9'h011;
   logic [31:0] rd_data_o;
   logic [31:0] v;
   logic scl, sda, tick, idle, ev, cl, irq;
   logic [31:0] exp_q[$];
   logic rd_d1 = 1'b0;
   int num_errors = 0;
   int n_tests = 0;
   int ticks;
   int pos[9] = '{0, 4, 6, 8, 11, 15, 16, 17, 19};
   // Divide by two runs last: the next divider write then follows a gap
   int dv[4] = '{0, 2, 7, 1};

   always #2.5 clock_i = ~clock_i;

   itci_bus_model i_itci_bus_model (.clock_i(clock_i), .scl_o(scl), .sda_o(sda));

   itci_top i_itci_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
      .scl_i(scl), .sda_i(sda), .master_waiting_i(flg[0]),
      .master_lost_arbitration_i(flg[1]), .master_start_stop_error_i(flg[2]),
      .slave_waiting_i(flg[3]), .slave_not_stretching_i(flg[4]),
      .slave_deselected_i(flg[5]), .monitor_ready_i(flg[6]), .monitor_overflow_i(flg[7]),
      .monitor_idle_i(flg[8]), .func_tick_o(tick), .bus_idle_o(idle),
      .event_gap_expired_o(ev), .clock_low_expired_o(cl), .irq_o(irq));

   task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_b(input logic got, input logic exp);
      cmp_w({31'h0, got}, {31'h0, exp});
   endtask

   // Strobes stay up between back-to-back accesses; cyc drops them
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      rd_en_i <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      addr_i <= a;
      wr_en_i <= 1'b0;
      rd_en_i <= 1'b1;
      @(posedge clock_i);
   endtask

   task automatic cyc(input int n);
      wr_en_i <= 1'b0;
      rd_en_i <= 1'b0;
      repeat (n) @(posedge clock_i);
   endtask

   function automatic logic [31:0] mk(input logic [8:0] f);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 9; i++) m[pos[i]] = f[i];
      return m;
   endfunction

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clock_i) begin
      if (rd_d1) cmp_w(rd_data_o, exp_q.pop_front());
      rd_d1 = rd_en_i;
   end

   initial begin
      repeat (6000) @(posedge clock_i);
      num_errors++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      void'($urandom(32'h3934E7AE));
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      rd(A_INT, 32'h0000FFFF);
      rd(A_DIV, 32'h0);
      rd(A_SET, 32'h801);
      rd(A_MSK, 32'h801);
      rd(A_TO, 32'h0);
      rd(A_CLR, 32'h0);
      rd(32'h4005001C, 32'h0);
      cyc(3);
      cmp_b(irq, 1'b1);
      $display("test reset done");
      v = $urandom;
      // Reserved upper halves are written as zero
      wr(A_INT, {16'h0, v[15:0]});
      rd(A_INT, {16'h0, v[15:4], 4'hF});
      wr(A_DIV, {16'h0, v[31:16]});
      rd(A_DIV, {16'h0, v[31:16]});
      wr(A_SET, 32'hFFFFFFFF);
      wr(A_CLR, 32'h0);
      rd(A_SET, 32'h030B8951);
      for (int i = 0; i < 9; i++) begin
         flg <= 9'h001 << i;
         rd(A_MSK, mk(9'h001 << i));
      end
      flg <= v[8:0];
      rd(A_MSK, mk(v[8:0]));
      for (int i = 0; i < 9; i++) wr(A_CLR, 32'h1 << pos[i]);
      rd(A_SET, 32'h03000000);
      wr(A_CLR, 32'h03000000);
      flg <= 9'h1FF;
      rd(A_MSK, 32'h0);
      cyc(3);
      cmp_b(irq, 1'b0);
      $display("test registers done");
      foreach (dv[k]) begin
         wr(A_DIV, dv[k]);
         cyc(8);
         ticks = 0;
         repeat (48) begin
            @(posedge clock_i);
            ticks += int'(tick);
         end
         cmp_w(ticks, 48 / (dv[k] + 1));
      end
      $display("test prescaler done");
      // Time-outs off around an interval change
      wr(A_CLR, 32'h03000000);
      wr(A_DIV, 32'h0);
      wr(A_INT, 32'h0000001F);
      wr(A_SET, 32'h02000000);
      flg <= 9'h000;
      cyc(1);
      i_itci_bus_model.put(1'b1, 1'b0, 18);
      cmp_b(idle, 1'b0);
      cmp_b(ev, 1'b0);
      cyc(30);
      cmp_b(ev, 1'b1);
      cmp_b(cl, 1'b0);
      cmp_b(irq, 1'b0);
      i_itci_bus_model.put(1'b0, 1'b0, 18);
      cmp_b(cl, 1'b0);
      i_itci_bus_model.put(1'b0, 1'b0, 30);
      cmp_b(cl, 1'b1);
      cmp_b(irq, 1'b1);
      rd(A_MSK, 32'h02000000);
      cyc(0);
      i_itci_bus_model.put(1'b1, 1'b0, 1);
      rd(A_TO, 32'h03000000);
      // Divide by two so the counters also see cycles without a tick
      wr(A_DIV, 32'h1);
      cyc(1);
      repeat (8) begin
         i_itci_bus_model.put(1'b0, 1'b0, 7);
         i_itci_bus_model.put(1'b1, 1'b0, 7);
      end
      cmp_b(ev, 1'b0);
      cmp_b(cl, 1'b0);
      cmp_b(irq, 1'b0);
      i_itci_bus_model.put(1'b1, 1'b1, 80);
      cmp_b(idle, 1'b1);
      cmp_b(ev, 1'b0);
      rd(A_TO, 32'h0);
      cyc(3);
      $display("test time-outs done");
      close_out();
   end

endmodule

// ===== common/itci_pkg.sv
/*
 * Constants for the bus time-out, function clock prescaler and masked
 * interrupt status block of the two-wire interface.
 * Assumes a 32-bit register port whose addresses are byte addresses.
 */
package itci_pkg;

   // Register byte addresses
   localparam logic [31:0] TO_STATUS_ADDR = 32'h4005_0004;
   localparam logic [31:0] IRQ_EN_SET_ADDR = 32'h4005_0008;
   localparam logic [31:0] IRQ_EN_CLR_ADDR = 32'h4005_000C;
   localparam logic [31:0] INTERVAL_ADDR = 32'h4005_0010;
   localparam logic [31:0] DIVIDER_ADDR = 32'h4005_0014;
   localparam logic [31:0] MASKED_STAT_ADDR = 32'h4005_0018;

   // Interval register layout and divider reset
   localparam int INTERVAL_LSB = 4;
   localparam logic [3:0] FIXED_LOW_BITS = 4'hF;
   localparam logic [11:0] INTERVAL_RST = 12'hFFF;
   localparam logic [15:0] DIVIDER_RST = 16'h0000;

   // Flag positions, shared by status, enable and masked status
   localparam int MST_WAIT_BIT = 0;
   localparam int MST_ARB_BIT = 4;
   localparam int MST_SSERR_BIT = 6;
   localparam int SLV_WAIT_BIT = 8;
   localparam int SLV_NOSTR_BIT = 11;
   localparam int SLV_DESEL_BIT = 15;
   localparam int MON_RDY_BIT = 16;
   localparam int MON_OV_BIT = 17;
   localparam int MON_IDLE_BIT = 19;
   localparam int EVT_GAP_BIT = 24;
   localparam int CLK_LOW_BIT = 25;

   localparam logic [31:0] IRQ_DEFINED_MASK = 32'h030B_8951;
   localparam logic [31:0] IRQ_EN_RST = 32'h0000_0801;
   localparam logic [31:0] TO_STATUS_MASK = 32'h0300_0000;

   // Pin filter: idle bus reads high on both lines
   localparam logic [1:0] PIN_RST = 2'h3;
   localparam int SCL_IDX = 0;
   localparam int SDA_IDX = 1;

endpackage

// ===== core/itci_top.sv
/*
 * Bus time-out monitors, function clock prescaler and masked interrupt
 * status view of a two-wire serial interface.
 * Assumes a single-cycle register port on clock_i, asynchronous serial
 * clock and data pins, and flag levels from master, slave and monitor
 * logic on the same clock.
 */
// The address-and-strobe port was left to the implementer.
// What this block does
// - While busy, time gaps between bus events; flag when a gap exceeds limit.
// - While busy, time only clock-low periods; flag when one exceeds limit.
// - Both checks share one interval and run together.
// - Time-out flags raise the interrupt only when their enable bit is set.
// - Low four interval bits are fixed ones: minimum and step of sixteen clocks.
// - Interval field bits 15:4 give (value+1)*16 clocks; resets to 0xFFF.
// - Function clock is block clock divided by divider field plus one.
// - Function clock times the time-out counters and master bus timing.
// - Masked status returns each flag ANDed with its enable bit.
// - Master flags at bits 0, 4, 6; master waiting reads one after reset.
// - Slave flags at bits 8, 11, 15; not stretching reads one after reset.
// - Monitor flags at bits 16, 17, 19; all reset to zero.
// - Time-out interrupt enables at bits 24 and 25; both reset disabled.
// - Writing one to enable clear disables that interrupt; zero does nothing.
module itci_top #(
   parameter int DIV_W = 16,
   parameter int TO_W = 12
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [31:0] rd_data_o,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic master_waiting_i,
   input wire logic master_lost_arbitration_i,
   input wire logic master_start_stop_error_i,
   input wire logic slave_waiting_i,
   input wire logic slave_not_stretching_i,
   input wire logic slave_deselected_i,
   input wire logic monitor_ready_i,
   input wire logic monitor_overflow_i,
   input wire logic monitor_idle_i,
   output logic func_tick_o,
   output logic bus_idle_o,
   output logic event_gap_expired_o,
   output logic clock_low_expired_o,
   output logic irq_o
);

   localparam int CNT_W = TO_W + 5;

   if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
      $error("DIV_W must lie in 1..16");
   end
   if (TO_W < 1 || TO_W > 12) begin : g_bad_to
      $error("TO_W must lie in 1..12");
   end

   logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_prev_q, pin_f_d;
   logic scl, sda, scl_prev, sda_prev;
   logic start_ev, stop_ev, scl_rise, scl_fall, any_event;
   logic busy_q;
   logic [DIV_W-1:0] div_q, div_cnt_q;
   logic tick;
   logic [TO_W-1:0] interval_q;
   logic [CNT_W-1:0] limit_w, evt_cnt_q, low_cnt_q;
   logic evt_hit, low_hit;
   logic [31:0] status_q, en_q, flags, masked;
   logic status_rd;
   logic irq_q;
   logic [31:0] rd_data_q;

   // Pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pin_s1_q <= itci_pkg::PIN_RST;
         pin_s2_q <= itci_pkg::PIN_RST;
         pin_s3_q <= itci_pkg::PIN_RST;
      end else begin
         pin_s1_q <= {sda_i, scl_i};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign pin_f_d = (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pin_f_q <= itci_pkg::PIN_RST;
         pin_prev_q <= itci_pkg::PIN_RST;
      end else begin
         pin_f_q <= pin_f_d;
         pin_prev_q <= pin_f_q;
      end
   end

   assign scl = pin_f_q[itci_pkg::SCL_IDX];
   assign sda = pin_f_q[itci_pkg::SDA_IDX];
   assign scl_prev = pin_prev_q[itci_pkg::SCL_IDX];
   assign sda_prev = pin_prev_q[itci_pkg::SDA_IDX];

   // Start and stop are data edges with the clock high before and after
   assign start_ev = sda_prev && !sda && scl && scl_prev;
   assign stop_ev = !sda_prev && sda && scl && scl_prev;
   assign scl_rise = scl && !scl_prev;
   assign scl_fall = !scl && scl_prev;
   assign any_event = start_ev || stop_ev || scl_rise || scl_fall;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         busy_q <= 1'b0;
      end else if (start_ev) begin
         busy_q <= 1'b1;
      end else if (stop_ev) begin
         busy_q <= 1'b0;
      end
   end

   assign bus_idle_o = !busy_q;

   // prescaler divide by field plus one
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         div_cnt_q <= '0;
      end else if (div_cnt_q >= div_q) begin
         div_cnt_q <= '0;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   assign tick = (div_cnt_q >= div_q);
   assign func_tick_o = tick;

   assign limit_w = {1'b0, interval_q, itci_pkg::FIXED_LOW_BITS} + CNT_W'(1);

   // restart on any event, hold at zero when idle
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !busy_q || any_event) begin
         evt_cnt_q <= '0;
      end else if (tick && evt_cnt_q != limit_w) begin
         evt_cnt_q <= evt_cnt_q + 1'b1;
      end
   end

   // restart at the fall
   // Starting at the fall keeps both checks in step on one shared limit
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !busy_q || scl || scl_fall) begin
         low_cnt_q <= '0;
      end else if (tick && low_cnt_q != limit_w) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end

   assign evt_hit = busy_q && !any_event && tick && (evt_cnt_q == limit_w - CNT_W'(1));
   assign low_hit = busy_q && !scl && tick && (low_cnt_q == limit_w - CNT_W'(1));

   assign status_rd = rd_en_i && (addr_i == itci_pkg::TO_STATUS_ADDR);

   // Sticky time-out flags; a new expiry beats a clearing read
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         status_q <= '0;
      end else begin
         if (status_rd) begin
            status_q <= '0;
         end
         if (evt_hit) begin
            status_q[itci_pkg::EVT_GAP_BIT] <= 1'b1;
         end
         if (low_hit) begin
            status_q[itci_pkg::CLK_LOW_BIT] <= 1'b1;
         end
      end
   end

   assign event_gap_expired_o = status_q[itci_pkg::EVT_GAP_BIT];
   assign clock_low_expired_o = status_q[itci_pkg::CLK_LOW_BIT];

   // Interval and divider; reserved upper bits are simply not stored
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         interval_q <= TO_W'(itci_pkg::INTERVAL_RST);
      end else if (wr_en_i && addr_i == itci_pkg::INTERVAL_ADDR) begin
         interval_q <= wr_data_i[itci_pkg::INTERVAL_LSB +: TO_W];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         div_q <= DIV_W'(itci_pkg::DIVIDER_RST);
      end else if (wr_en_i && addr_i == itci_pkg::DIVIDER_ADDR) begin
         div_q <= wr_data_i[DIV_W-1:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         en_q <= itci_pkg::IRQ_EN_RST;
      end else if (wr_en_i && addr_i == itci_pkg::IRQ_EN_SET_ADDR) begin
         en_q <= en_q | (wr_data_i & itci_pkg::IRQ_DEFINED_MASK);
      end else if (wr_en_i && addr_i == itci_pkg::IRQ_EN_CLR_ADDR) begin
         en_q <= en_q & ~wr_data_i;
      end
   end

   always_comb begin
      flags = status_q & itci_pkg::TO_STATUS_MASK;
      flags[itci_pkg::MST_WAIT_BIT] = master_waiting_i;
      flags[itci_pkg::MST_ARB_BIT] = master_lost_arbitration_i;
      flags[itci_pkg::MST_SSERR_BIT] = master_start_stop_error_i;
      flags[itci_pkg::SLV_WAIT_BIT] = slave_waiting_i;
      flags[itci_pkg::SLV_NOSTR_BIT] = slave_not_stretching_i;
      flags[itci_pkg::SLV_DESEL_BIT] = slave_deselected_i;
      flags[itci_pkg::MON_RDY_BIT] = monitor_ready_i;
      flags[itci_pkg::MON_OV_BIT] = monitor_overflow_i;
      flags[itci_pkg::MON_IDLE_BIT] = monitor_idle_i;
   end

   assign masked = flags & en_q;

   // only enabled flags reach the interrupt
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |masked;
      end
   end

   assign irq_o = irq_q;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !rd_en_i) begin
         rd_data_q <= '0;
      end else begin
         unique case (addr_i)
            itci_pkg::TO_STATUS_ADDR: rd_data_q <= status_q;
            itci_pkg::IRQ_EN_SET_ADDR: rd_data_q <= en_q;
            itci_pkg::INTERVAL_ADDR: rd_data_q <=
               32'({interval_q, itci_pkg::FIXED_LOW_BITS});
            itci_pkg::DIVIDER_ADDR: rd_data_q <= 32'(div_q);
            itci_pkg::MASKED_STAT_ADDR: rd_data_q <= masked;
            default: rd_data_q <= '0;
         endcase
      end
   end

   assign rd_data_o = rd_data_q;

   AST_EVT_GAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      evt_hit |=> event_gap_expired_o)
      else $error("event gap expiry not flagged");

   // expiry follows a busy clock-low cycle with a tick
   AST_CLK_LOW: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(clock_low_expired_o) |-> $past(!scl && busy_q && tick))
      else $error("clock low flag without a low period");

   // when both counters hit in the same cycle, both flags are set
   AST_SAME_LIMIT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (evt_hit && low_hit) |=> (event_gap_expired_o && clock_low_expired_o))
      else $error("shared limit did not expire both checks");

   // no interrupt without an enabled flag
   AST_IRQ_MASK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !(|(flags & en_q)) |=> !irq_o)
      else $error("interrupt raised with nothing enabled");

   // low interval bits read as ones
   AST_FIXED_LOW: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (rd_en_i && addr_i == itci_pkg::INTERVAL_ADDR) |=> rd_data_o[3:0] == 4'hF)
      else $error("fixed interval bits not read as ones");

   AST_LIMIT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (wr_en_i && addr_i == itci_pkg::INTERVAL_ADDR) |=>
      limit_w == ((CNT_W'($past(wr_data_i[15:4])) + CNT_W'(1)) << 4))
      else $error("interval limit wrong after write");

   // divide by two gives alternating ticks
   AST_DIV_TWO: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (tick && div_q == DIV_W'(1) && !wr_en_i) |=> !tick ##1 tick)
      else $error("divide by two spacing wrong");

   // event counter moves only on a tick
   AST_TICK_ONLY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (busy_q && !tick && !any_event && $past(busy_q)) |=> $stable(evt_cnt_q))
      else $error("event counter moved without a tick");

   AST_MASKED_READ: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (rd_en_i && addr_i == itci_pkg::MASKED_STAT_ADDR) |=>
      rd_data_o == $past(flags & en_q))
      else $error("masked status read mismatch");

   // monitor ready lands on bit 16
   AST_MON_BIT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (rd_en_i && addr_i == itci_pkg::MASKED_STAT_ADDR && monitor_ready_i
      && en_q[16]) |=> rd_data_o[16])
      else $error("monitor ready not at bit 16");

   AST_EN_SET: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (wr_en_i && addr_i == itci_pkg::IRQ_EN_SET_ADDR) |=>
      (en_q[25:24] & $past(wr_data_i[25:24])) == $past(wr_data_i[25:24]))
      else $error("enable set write lost");

   AST_EN_CLR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (wr_en_i && addr_i == itci_pkg::IRQ_EN_CLR_ADDR) |=>
      (en_q & $past(wr_data_i)) == 32'h0000_0000)
      else $error("enable clear write ignored");

   AST_RESTART: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      any_event |=> evt_cnt_q == '0)
      else $error("event counter not restarted");

   COV_EVT: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(event_gap_expired_o));
   COV_LOW: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(clock_low_expired_o));
   COV_IRQ: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(irq_o));
   COV_SET_CLR: cover property (@(posedge clock_i) disable iff (sys_rst_i)
      status_rd && (evt_hit || low_hit));

endmodule
